// ---- sto_monitor.sv ----
// Dual-channel torque-off input monitor top.
// Assumes asynchronous pins, one 20 MHz clock, and that the outside
// keeps its own stop-sequence duties.
`timescale 1ns/10ps
// Behaviour
// - Input A open cuts channel A drive; closed releases it.
// - Input B open cuts channel B drive; closed releases it.
// - Monitor A closed while channel A shut off, open when released.
// - Monitor B closed while channel B shut off, open when released.
// - Overall shut-off whenever either input off; series path non-conducting with only one off, conducting with both off.
// - Release only with both inputs on, power good, no alarm or warning.
// - Inputs dropped while running: stop by dynamic braking.
// - Timing error selection one disables torque-off timing error detection.
module sto_monitor
   import sto_pkg::*;
(
   input  wire logic i_clk,               // System clock, 20 MHz
   input  wire logic i_rst,               // Sync reset, active high
   input  wire logic i_torque_off_in_a,   // 1 = input A closed
   input  wire logic i_torque_off_in_b,   // 1 = input B closed
   input  wire logic i_power_ok,          // Power on
   input  wire logic i_alarm,             // Alarm or warning active
   input  wire logic i_motor_moving,      // Motor speed not zero
   input  wire logic i_servo_on,          // Servo-on command
   input  wire logic i_forced_stop_one,   // 1 = forced stop one on (not stopping)
   input  wire logic i_terr_sel,          // Timing error selection
   output logic      o_drive_en_a,        // Channel A base drive allowed
   output logic      o_drive_en_b,        // Channel B base drive allowed
   output logic      o_shutoff_monitor_a, // 1 = monitor A closed
   output logic      o_shutoff_monitor_b, // 1 = monitor B closed
   output logic      o_series_closed,     // Series path A-B conducting
   output logic      o_sto_active,        // Overall torque-off state
   output logic      o_dyn_brake,         // Dynamic brake engaged
   output logic      o_timing_err         // Shut-off while servo still enabled
);
   // ****************************************
   // Input synchronisation
   // ****************************************
   sto_ch_if ch_a ();
   sto_ch_if ch_b ();

   assign ch_a.raw = i_torque_off_in_a;
   assign ch_b.raw = i_torque_off_in_b;

   sto_sync u_sync_a (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .ch    (ch_a)
   );

   sto_sync u_sync_b (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .ch    (ch_b)
   );

   // ****************************************
   // Overall state machine
   // ****************************************
   sto_state_t state_ff;
   sto_state_t nxt_state;
   logic       mon_a_ff;
   logic       nxt_mon_a;
   logic       mon_b_ff;
   logic       nxt_mon_b;
   logic       terr_ff;
   logic       nxt_terr;
   logic       both_on;

   assign both_on = ch_a.closed & ch_b.closed;

   // Next state; release needs every condition, any loss shuts off
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         STO_ST_OFF: begin
            if (both_on && i_power_ok && !i_alarm) begin
               nxt_state = STO_ST_RUN;
            end
         end
         STO_ST_RUN: begin
            if (!both_on || !i_power_ok || i_alarm) begin
               nxt_state = i_motor_moving ? STO_ST_DB : STO_ST_OFF;
            end
         end
         STO_ST_DB: begin
            // Braking holds until the motor halts; no restart mid-brake
            if (!i_motor_moving) begin
               nxt_state = STO_ST_OFF;
            end
         end
         default: begin
            nxt_state = STO_ST_OFF;
         end
      endcase
   end

   // Monitor outputs follow each channel
   always_comb begin
      nxt_mon_a = ~ch_a.closed;
      nxt_mon_b = ~ch_b.closed;
   end

   // Timing error: shut-off with servo still on and forced stop one not applied
   always_comb begin
      nxt_terr = terr_ff;
      if (i_terr_sel == TERR_OFF_SEL) begin
         nxt_terr = 1'b0;
      end else if (state_ff == STO_ST_RUN && !both_on && i_servo_on && i_forced_stop_one) begin
         nxt_terr = 1'b1;
      end else if (state_ff == STO_ST_OFF && !i_servo_on) begin
         nxt_terr = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_ff <= STO_ST_OFF;
         mon_a_ff <= RST_MON_LEVEL;
         mon_b_ff <= RST_MON_LEVEL;
         terr_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         mon_a_ff <= nxt_mon_a;
         mon_b_ff <= nxt_mon_b;
         terr_ff  <= nxt_terr;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // channel A drive gate
   assign o_drive_en_a        = (state_ff == STO_ST_RUN) & ch_a.closed;
   assign o_drive_en_b        = (state_ff == STO_ST_RUN) & ch_b.closed;
   assign o_shutoff_monitor_a = mon_a_ff;
   assign o_shutoff_monitor_b = mon_b_ff;
   // series path conducts only with both shut off
   assign o_series_closed     = mon_a_ff & mon_b_ff;
   assign o_sto_active        = (state_ff != STO_ST_RUN);
   assign o_dyn_brake         = (state_ff == STO_ST_DB);
   assign o_timing_err        = terr_ff;

   // ****************************************
   // Assertions
   // ****************************************
   property p_mon_a;
      @(posedge i_clk) disable iff (i_rst)
      !ch_a.closed |=> o_shutoff_monitor_a;
   endproperty
   a_mon_a: assert property (p_mon_a) else $error("monitor A not closed after input A open");

   property p_mon_b;
      @(posedge i_clk) disable iff (i_rst)
      ch_b.closed |=> !o_shutoff_monitor_b;
   endproperty
   a_mon_b: assert property (p_mon_b) else $error("monitor B not open after input B closed");

   property p_drive_a;
      @(posedge i_clk) disable iff (i_rst)
      !i_torque_off_in_a |-> ##2 !o_drive_en_a;
   endproperty
   a_drive_a: assert property (p_drive_a) else $error("drive A enabled with input A open");

   property p_drive_b;
      @(posedge i_clk) disable iff (i_rst)
      !i_torque_off_in_b |-> ##2 !o_drive_en_b;
   endproperty
   a_drive_b: assert property (p_drive_b) else $error("drive B enabled with input B open");

   property p_either_off;
      @(posedge i_clk) disable iff (i_rst)
      (!ch_a.closed ^ !ch_b.closed) ##1 (!ch_a.closed ^ !ch_b.closed) |-> o_sto_active && !o_series_closed;
   endproperty
   a_either_off: assert property (p_either_off) else $error("single channel off not held");

   property p_release;
      @(posedge i_clk) disable iff (i_rst)
      o_sto_active && $past(o_sto_active) ##1 !o_sto_active |-> $past(both_on && i_power_ok && !i_alarm);
   endproperty
   a_release: assert property (p_release) else $error("release without all conditions");

   property p_brake;
      @(posedge i_clk) disable iff (i_rst)
      (state_ff == STO_ST_RUN) && !both_on && i_motor_moving |=> o_dyn_brake;
   endproperty
   a_brake: assert property (p_brake) else $error("no dynamic brake on shut-off while moving");

   property p_terr_off;
      @(posedge i_clk) disable iff (i_rst)
      i_terr_sel == TERR_OFF_SEL |=> !o_timing_err;
   endproperty
   a_terr_off: assert property (p_terr_off) else $error("timing error flagged while detection off");

   property p_sync;
      @(posedge i_clk) disable iff (i_rst)
      i_torque_off_in_a ##1 i_torque_off_in_a |=> ch_a.closed;
   endproperty
   a_sync: assert property (p_sync) else $error("input A not through synchroniser in two cycles");

   property p_mon_a_rel;
      @(posedge i_clk) disable iff (i_rst)
      ch_a.closed |=> !o_shutoff_monitor_a;
   endproperty
   a_mon_a_rel: assert property (p_mon_a_rel) else $error("monitor A not open after input A closed");

   property p_mon_b_off;
      @(posedge i_clk) disable iff (i_rst)
      !ch_b.closed |=> o_shutoff_monitor_b;
   endproperty
   a_mon_b_off: assert property (p_mon_b_off) else $error("monitor B not closed after input B open");

   property p_sto_hold;
      @(posedge i_clk) disable iff (i_rst)
      !both_on |=> o_sto_active;
   endproperty
   a_sto_hold: assert property (p_sto_hold) else $error("released with an input open");

   property p_brake_end;
      @(posedge i_clk) disable iff (i_rst)
      o_dyn_brake && !i_motor_moving |=> !o_dyn_brake && o_sto_active;
   endproperty
   a_brake_end: assert property (p_brake_end) else $error("dynamic brake not ended at standstill");

   property p_terr_set;
      @(posedge i_clk) disable iff (i_rst)
      (i_terr_sel != TERR_OFF_SEL) && (state_ff == STO_ST_RUN) && !both_on && i_servo_on && i_forced_stop_one
         |=> o_timing_err;
   endproperty
   a_terr_set: assert property (p_terr_set) else $error("timing error not flagged while detection on");
endmodule : sto_monitor

// ---- sto_pkg.sv ----
// Package for the dual-channel torque-off input monitor.
// Assumes a single 20 MHz clock and synchronous active-high reset.
package sto_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned CLK_PERIOD_NS   = 50;
   // Longest diagnostic pulse the outside may send, in microseconds
   localparam int unsigned TEST_PULSE_US   = 1000;
   // Longest time rounds down to whole cycles
   localparam int unsigned TEST_PULSE_CYC  = (TEST_PULSE_US * (CLK_HZ / 1_000_000));
   // Synchroniser depth
   localparam int unsigned SYNC_STAGES     = 2;
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic        RST_IN_LEVEL    = 1'b0;
   localparam logic        RST_MON_LEVEL   = 1'b1;
   // Timing error selection value that turns detection off
   localparam logic        TERR_OFF_SEL    = 1'b1;
   // ****************************************
   // Overall state
   // ****************************************
   typedef enum logic [2:0] {
      STO_ST_OFF   = 3'b001,
      STO_ST_DB    = 3'b010,
      STO_ST_RUN   = 3'b100
   } sto_state_t;
endpackage : sto_pkg

// ---- sto_ch_if.sv ----
// Interface carrying one synchronised torque-off channel.
// Assumes the producer and the monitor share i_clk.
`timescale 1ns/10ps
interface sto_ch_if;
   logic raw;      // Input level from the pin
   logic closed;   // Synchronised level, 1 = closed
   modport sync (input raw, output closed);
   modport mon  (output raw, input closed);
endinterface : sto_ch_if

// ---- sto_sync.sv ----
// Two-stage synchroniser for one torque-off input.
// Assumes the pin level may change at any time.
`timescale 1ns/10ps
module sto_sync
   import sto_pkg::*;
(
   input  wire logic i_clk,   // System clock
   input  wire logic i_rst,   // Sync reset, active high
   sto_ch_if.sync    ch       // Channel carrier
);
   // ****************************************
   // Synchroniser
   // ****************************************
   logic [SYNC_STAGES-1:0] sync_ff;
   logic [SYNC_STAGES-1:0] nxt_sync;

   // Shift chain; only the last stage is read outside
   always_comb begin
      nxt_sync = {sync_ff[SYNC_STAGES-2:0], ch.raw};
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sync_ff <= {SYNC_STAGES{RST_IN_LEVEL}};
      end else begin
         sync_ff <= nxt_sync;
      end
   end

   assign ch.closed = sync_ff[SYNC_STAGES-1];
endmodule : sto_sync

// ---- sto_relay_model.sv ----
// Safety relay model driving both torque-off inputs.
// Assumes bench commands that change at the falling edge.
`timescale 1ns/10ps
module sto_relay_model (
   input  wire logic       i_clk,          // System clock
   input  wire logic       i_on,           // Close both channels
   input  wire logic [1:0] i_one_off,      // Commanded fault: open A (bit 0) or B (bit 1) alone
   input  wire logic [7:0] i_pulse,        // Test pulse length in cycles, 0 = none
   output logic            o_in_a = 1'b0,  // Torque-off input A, 1 = closed
   output logic            o_in_b = 1'b0   // Torque-off input B, 1 = closed
);
   // ****************************************
   // Contact drive
   // ****************************************
   logic [7:0] cnt_ff  = 8'h00;
   logic       on_q    = 1'b0;
   logic [1:0] off_q   = 2'b00;
   logic [7:0] pulse_q = 8'h00;
   // Take commands at the rising edge, where the bench has settled them;
   // reading them at the falling edge would race the bench's own writes
   always @(posedge i_clk) begin
      on_q    <= i_on;
      off_q   <= i_one_off;
      pulse_q <= i_pulse;
   end
   // Drive off the falling edge, clear of the sampling edge
   always @(negedge i_clk) begin
      if (pulse_q != 8'h00 && cnt_ff == 8'h00) cnt_ff <= pulse_q;
      else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
      o_in_a <= on_q & ~off_q[0] & (cnt_ff == 8'h00);
      o_in_b <= on_q & ~off_q[1] & (cnt_ff == 8'h00);
   end
endmodule : sto_relay_model

// ---- tb.sv ----
// Self-checking bench for the torque-off input monitor.
// Assumes the relay model drives both inputs; the bench drives the rest.
`timescale 1ns/10ps
module tb;
   import sto_pkg::*;
   // ****************************************
   // Signals
   // ****************************************
   logic        i_clk, i_rst, on, pwr, alarm, moving, servo, fs1, tsel;
   logic [1:0]  one_off;
   logic [7:0]  pulse;
   logic        in_a, in_b, en_a, en_b, mon_a, mon_b, ser, sto, db, terr;
   logic [5:0]  exp_q[$];
   logic [5:0]  vec, prev;
   logic [31:0] seed = 32'hf88b_5637;
   int          num_errors = 0;
   int          checks = 0;
   assign vec = {mon_a, mon_b, ser, sto, db, terr};

   sto_relay_model u_sto_relay_model (.i_clk(i_clk), .i_on(on), .i_one_off(one_off), .i_pulse(pulse),
      .o_in_a(in_a), .o_in_b(in_b));
   sto_monitor u_sto_monitor (.i_clk(i_clk), .i_rst(i_rst), .i_torque_off_in_a(in_a),
      .i_torque_off_in_b(in_b), .i_power_ok(pwr), .i_alarm(alarm), .i_motor_moving(moving),
      .i_servo_on(servo), .i_forced_stop_one(fs1), .i_terr_sel(tsel), .o_drive_en_a(en_a),
      .o_drive_en_b(en_b), .o_shutoff_monitor_a(mon_a), .o_shutoff_monitor_b(mon_b),
      .o_series_closed(ser), .o_sto_active(sto), .o_dyn_brake(db), .o_timing_err(terr));

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic cmp(input logic [5:0] got, input logic [5:0] e);
      checks++;
      if (got !== e) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %b expected %b", $time, got, e);
      end
   endtask : cmp
   // Note the outcome, then let it settle
   task automatic step(input logic [5:0] e);
      exp_q.push_back(e);
      repeat (12) @(negedge i_clk);
   endtask : step
   task automatic stop_test();
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test

   // Clock and watchdog
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      num_errors++;
      stop_test();
   end

   // Watcher: compare a few edges after a change, since outputs may skew by a cycle
   initial begin
      @(negedge i_rst);
      prev = vec;
      forever begin
         @(posedge i_clk);
         #1;
         if (vec !== prev) begin
            repeat (3) @(posedge i_clk);
            #1;
            if (exp_q.size() == 0) cmp(vec, ~vec);
            else cmp(vec, exp_q.pop_front());
            prev = vec;
         end
      end
   end

   // ****************************************
   // Stimulus, order: [mon_a mon_b series sto brake terr]
   // ****************************************
   initial begin
      i_rst = 1'b1; on = 1'b0; one_off = 2'b00; pulse = 8'h00; pwr = 1'b1;
      alarm = 1'b0; moving = 1'b0; servo = 1'b0; fs1 = 1'b1; tsel = 1'b0;
      repeat (6) @(negedge i_clk);
      i_rst = 1'b0;
      @(negedge i_clk);
      cmp(vec, 6'b111100);
      on = 1'b1;
      step(6'b000000);
      cmp({4'h0, en_a, en_b}, 6'b000011);
      one_off = 2'b10;
      step(6'b010100);
      cmp({5'h00, en_b}, 6'b000000);
      one_off = 2'b00;
      step(6'b000000);
      one_off = 2'b01;
      step(6'b100100);
      cmp({5'h00, en_a}, 6'b000000);
      on = 1'b0;
      one_off = 2'b00;
      step(6'b111100);
      alarm = 1'b1;
      on = 1'b1;
      step(6'b000100);
      alarm = 1'b0;
      step(6'b000000);
      // Shut-off while running with servo still on
      servo = 1'b1; moving = 1'b1; on = 1'b0;
      step(6'b111111);
      moving = 1'b0;
      step(6'b111101);
      servo = 1'b0;
      step(6'b111100);
      on = 1'b1;
      step(6'b000000);
      servo = 1'b1; tsel = TERR_OFF_SEL; moving = 1'b1; on = 1'b0;
      step(6'b111110);
      moving = 1'b0; servo = 1'b0;
      step(6'b111100);
      tsel = 1'b0; on = 1'b1;
      step(6'b000000);
      // forced stop one applied first, so no timing error
      servo = 1'b1; fs1 = 1'b0; moving = 1'b1;
      repeat (4) @(negedge i_clk);
      // inputs drop only once the motor is at rest
      moving = 1'b0; on = 1'b0;
      step(6'b111100);
      fs1 = 1'b1; servo = 1'b0; on = 1'b1;
      step(6'b000000);
      // Random short test pulses, each shuts off and then releases
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         pulse = 8'h06 + {5'h00, seed[2:0]};
         exp_q.push_back(6'b111100);
         @(negedge i_clk);
         pulse = 8'h00;
         step(6'b000000);
         repeat (20) @(negedge i_clk);
      end
      if (exp_q.size() != 0) cmp(6'b000000, 6'b111111);
      stop_test();
   end
endmodule : tb
